// *** bench/chan_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far side: timer channels that count enables and hold run flags
module chan_model
   import tau_pkg::*;
(
   input  wire logic                  core_clk, // system clock
   input  wire logic                  clear,    // zero the counts
   input  wire logic                  go,       // start all channels
   input  wire logic                  halt,     // stop all channels
   input  wire unit_operation_clock_s u0,       // unit 0 enables
   input  wire unit_operation_clock_s u1,       // unit 1 enables
   output logic [CH_NUM-1:0]          running,  // run flags
   output logic [16:0]                cnt [4]   // u0c0 u0c1 u1c0 u1c1
);
   always_ff @(posedge core_clk) begin
      if (halt) running <= '0;
      else if (go) running <= '1;
   end
   // an unknown enable poisons its count, so it cannot pass unseen
   always_ff @(posedge core_clk) begin
      if (clear) cnt <= '{default: '0};
      else begin
         cnt[0] <= cnt[0] + 17'(u0.clk0);
         cnt[1] <= cnt[1] + 17'(u0.clk1);
         cnt[2] <= cnt[2] + 17'(u1.clk0);
         cnt[3] <= cnt[3] + 17'(u1.clk1);
      end
   end
endmodule : chan_model
`default_nettype wire

// *** bench/timer_unit_prescaler_select_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_unit_prescaler_select_tb
   import tau_pkg::*;
;
   logic                  core_clk, rstn, hsel, hwrite, hreadyout, hresp;
   logic                  clear, go, halt, rdy_s;
   logic [31:0]           haddr, hwdata, hrdata, hrdata_s, rd;
   logic [1:0]            htrans;
   logic [2:0]            hsize;
   logic [CH_NUM-1:0]     running, set_ev, reset_ev, pin;
   logic [16:0]           cnt [4];
   unit_operation_clock_s u0, u1;
   int                    n_mismatch, n_compared;

   timer_prescaler_top i_dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .unit0_op_clk(u0), .unit1_op_clk(u1),
      .channel_running_flag(running), .set_event(set_ev),
      .reset_event(reset_ev), .timer_output_pin(pin));
   chan_model i_chan (.core_clk(core_clk), .clear(clear), .go(go),
      .halt(halt), .u0(u0), .u1(u1), .running(running), .cnt(cnt));

   // clock generation
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // bus answer copied mid-cycle, so the edge that takes it never races
   always @(negedge core_clk) begin
      hrdata_s = hrdata;
      rdy_s = hreadyout;
   end

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // waits for hready at a rising edge, never forever
   task automatic edge_ready;
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (rdy_s !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_mismatch++;
         $display("[FAIL] %0t bus hang", $time);
         close_out();
      end
   endtask : edge_ready

   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      hsize <= 3'h2;
      edge_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_ready();
      rd = hrdata_s;
   endtask : bus

   task automatic pulse(input logic [7:0] s, input logic [7:0] r);
      set_ev <= s;
      reset_ev <= r;
      @(posedge core_clk);
      set_ev <= '0;
      reset_ev <= '0;
      // pins launched at the event edge are read, settled, at the next one
      @(posedge core_clk);
   endtask : pulse

   task automatic t_regs;
      bus(0, UNIT0_SELECT_ADDR, 0);
      chk(rd, 32'h0, "sel0 reset");
      bus(0, UNIT1_SELECT_ADDR, 0);
      chk(rd, 32'h0, "sel1 reset");
      chk(32'(hresp), 32'(HRESP_OKAY), "okay response");
      bus(1, UNIT0_SELECT_ADDR, 32'h0000_00A5);
      bus(1, UNIT1_SELECT_ADDR, 32'h0000_005A);
      bus(1, 32'h0000_0100, 32'hFFFF_FFFF);
      bus(0, 32'h0000_0100, 0);
      chk(rd, 32'h0, "unmapped");
      bus(0, UNIT0_SELECT_ADDR, 0);
      chk(rd, 32'hA5, "sel0 rw");
      bus(0, UNIT1_SELECT_ADDR, 0);
      chk(rd, 32'h5A, "sel1 rw");
      // second reset in mid-run must clear the select again
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      bus(0, UNIT0_SELECT_ADDR, 0);
      chk(rd, 32'h0, "sel0 rereset");
      $display("test regs done");
   endtask : t_regs

   task automatic t_divide;
      int w;
      int e;
      pulse(0, 0);
      halt <= 1'b1;
      for (int n = 0; n < 16; n++) begin
         // the longest codes get a one-period window to keep the run short
         e = (n > 12) ? 1 : 2;
         w = e << n;
         bus(1, UNIT0_SELECT_ADDR, {24'h0, 4'h0, 4'(n)});
         bus(1, UNIT1_SELECT_ADDR, {24'h0, 4'(n), 4'h0});
         repeat (3) @(posedge core_clk);
         clear <= 1'b1;
         @(posedge core_clk);
         clear <= 1'b0;
         // one extra edge: counts are read before that edge updates them
         repeat (w + 1) @(posedge core_clk);
         chk(32'(cnt[0]), 32'(e), "u0 clk0");
         chk(32'(cnt[1]), 32'(w), "u0 clk1");
         chk(32'(cnt[2]), 32'(w), "u1 clk0");
         chk(32'(cnt[3]), 32'(e), "u1 clk1");
      end
      halt <= 1'b0;
      $display("test divide done");
   endtask : t_divide

   task automatic t_output;
      pulse(8'h89, 8'h08);
      chk(32'(pin), 32'h89, "set wins");
      pulse(8'h00, 8'h81);
      chk(32'(pin), 32'h08, "reset");
      bus(1, OUT_CTRL_ADDR, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      chk(32'(pin), 32'h09, "polarity now");
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      bus(1, OUT_CTRL_ADDR, 32'h0000_0101);
      bus(1, OUT_CTRL_ADDR, 32'h0000_0100);
      repeat (3) @(posedge core_clk);
      chk(32'(pin), 32'h09, "polarity held");
      bus(0, OUT_STATUS_ADDR, 0);
      chk(rd, 32'h0000_09FF, "status");
      pulse(8'h00, 8'h01);
      chk(32'(pin), 32'h08, "polarity applied");
      $display("test output done");
   endtask : t_output

   // stimulus
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      set_ev = '0;
      reset_ev = '0;
      clear = 1'b1;
      go = 1'b0;
      halt = 1'b1;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      clear <= 1'b0;
      halt <= 1'b0;
      t_regs();
      t_divide();
      t_output();
      close_out();
   end
endmodule : timer_unit_prescaler_select_tb
`default_nettype wire

// *** logic/prescale_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module prescale_unit
   import tau_pkg::*;
(
   input  wire logic                  core_clk, // system clock
   input  wire logic                  rstn,     // sync reset, active low
   input  wire divide_code_field_s    codes,    // divide codes of this unit
   output var unit_operation_clock_s  op_en     // one-cycle enable pulses
);
   logic [PRE_W-1:0] count;

   // free-running divider; never reset by code writes so both clocks
   // stay phase aligned with each other
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   // enables are registered so channel logic sees glitch-free strobes
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         op_en <= '0;
      end else begin
         // RULE1 divide by power of two
         // RULE9 enable from counter
         op_en.clk0 <= pulse_due(count, codes.clk0_code);
         op_en.clk1 <= pulse_due(count, codes.clk1_code);
      end
   end

   sequence held0_div2;
      codes.clk0_code == 4'h1 && $past(codes.clk0_code) == 4'h1;
   endsequence

   sequence held1_div8;
      codes.clk1_code == 4'h3 && $past(codes.clk1_code) == 4'h3;
   endsequence

   property div2_rhythm;
      @(posedge core_clk) disable iff (!rstn)
      op_en.clk0 ##0 held0_div2 |=> (!op_en.clk0 || codes.clk0_code != 4'h1)
         ##1 (op_en.clk0 || codes.clk0_code != 4'h1);
   endproperty

   div2_pulse_a: assert property (div2_rhythm) // RULE1
      else $error("first clock at divide 2 lost its rhythm");

   div8_pulse_a: assert property ( // RULE9
      @(posedge core_clk) disable iff (!rstn)
      op_en.clk1 ##0 held1_div8 |=>
         (!op_en.clk1 || codes.clk1_code != 4'h3)[*7]
         ##1 (op_en.clk1 || codes.clk1_code != 4'h3))
      else $error("second clock at divide 8 not one pulse in eight");

   undivided_en_a: assert property ( // RULE1
      @(posedge core_clk) disable iff (!rstn)
      codes.clk0_code == 4'h0 |=> op_en.clk0)
      else $error("code zero must give an enable every cycle");
endmodule : prescale_unit
`default_nettype wire

// *** logic/tau_pkg.sv ***
// Function
// RULE1: two operation clocks, codes in bits 3..0 and 7..4, clock divided by 2**code
// RULE2: software writes zeros to bits 15..8 of the select register
// RULE3: select register resets to zero and is readable and writable
// RULE4: unit 0 select at index F01B6, unit 1 select at index F01DE
// RULE5: software stops all channels before changing the system clock choice
// RULE6: software stops the unit when a clock change touches a channel count clock
// RULE7: slave output mode, polarity write while running waits for next output event
// RULE8: set drives output inactive to active, reset drives it back to inactive
// RULE9: each operation clock is a one-cycle enable from a free-running counter
`default_nettype none
package tau_pkg;
   localparam int CODE_W = 4;
   localparam int PRE_W  = 15;
   localparam int CH_NUM = 8;

   // register indices; byte address is four times the index
   localparam logic [19:0] UNIT0_SELECT_IDX = 20'hF01B6;
   localparam logic [19:0] UNIT1_SELECT_IDX = 20'hF01DE;
   localparam logic [19:0] OUT_CTRL_IDX     = 20'hF01B8;
   localparam logic [19:0] OUT_STATUS_IDX   = 20'hF01BA;
   localparam logic [31:0] UNIT0_SELECT_ADDR = {10'h000, UNIT0_SELECT_IDX, 2'b00};
   localparam logic [31:0] UNIT1_SELECT_ADDR = {10'h000, UNIT1_SELECT_IDX, 2'b00};
   localparam logic [31:0] OUT_CTRL_ADDR     = {10'h000, OUT_CTRL_IDX, 2'b00};
   localparam logic [31:0] OUT_STATUS_ADDR   = {10'h000, OUT_STATUS_IDX, 2'b00};

   // field positions
   localparam int CLK0_LSB     = 0;
   localparam int CLK1_LSB     = 4;
   localparam int POL_LSB      = 0;
   localparam int MODE_LSB     = 8;
   localparam int RUN_LSB      = 0;
   localparam int PIN_LSB      = 8;

   // reset values
   localparam logic [7:0] SELECT_RST = 8'h00;
   localparam logic [7:0] POL_RST    = 8'h00;
   localparam logic [7:0] MODE_RST   = 8'h00;

   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef struct packed {
      logic [CODE_W-1:0] clk1_code;  // second operation clock code
      logic [CODE_W-1:0] clk0_code;  // first operation clock code
   } divide_code_field_s;

   typedef struct packed {
      logic clk1;                    // enable of second operation clock
      logic clk0;                    // enable of first operation clock
   } unit_operation_clock_s;

   // true when the low code bits of the counter are all ones
   function automatic logic pulse_due(input logic [PRE_W-1:0]  cnt,
                                      input logic [CODE_W-1:0] code);
      logic [PRE_W-1:0] mask;
      mask = PRE_W'((16'h0001 << code) - 16'h0001);
      return (cnt & mask) == mask;
   endfunction : pulse_due
endpackage : tau_pkg
`default_nettype wire

// *** logic/timer_prescaler_top.sv ***
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_top
   import tau_pkg::*;
(
   input  wire logic              core_clk,             // 25 MHz clock
   input  wire logic              rstn,                 // sync reset, low
   input  wire logic              hsel,                 // slave select
   input  wire logic [31:0]       haddr,                // byte address
   input  wire logic [1:0]        htrans,               // transfer type
   input  wire logic              hwrite,               // write when high
   input  wire logic [2:0]        hsize,                // transfer size
   input  wire logic [31:0]       hwdata,               // write data
   input  wire logic              hready,               // bus ready
   output logic                   hreadyout,            // always ready
   output logic [31:0]            hrdata,               // read data
   output logic                   hresp,                // always okay
   output var unit_operation_clock_s unit0_op_clk,      // unit 0 enables
   output var unit_operation_clock_s unit1_op_clk,      // unit 1 enables
   input  wire logic [CH_NUM-1:0] channel_running_flag, // channel runs
   input  wire logic [CH_NUM-1:0] set_event,            // go active
   input  wire logic [CH_NUM-1:0] reset_event,          // go inactive
   output logic [CH_NUM-1:0]      timer_output_pin      // channel outputs
);
   divide_code_field_s       select0;
   divide_code_field_s       select1;
   logic [CH_NUM-1:0]        polarity;
   logic [CH_NUM-1:0]        slave_output_mode_bit;
   logic [CH_NUM-1:0]        out_active;
   logic [CH_NUM-1:0]        eff_pol;
   logic [CH_NUM-1:0]        next_active;
   logic [CH_NUM-1:0]        next_pol;
   logic                     wr_pend;
   logic [31:0]              wr_addr;
   logic                     addr_take;

   // zero wait states: every transfer finishes in its first data cycle
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign addr_take = hsel && (htrans == HTRANS_NONSEQ) && hready;

   // read mux shared by the address-phase capture
   function automatic logic [31:0] read_word(input logic [31:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         // RULE2 upper byte reads zero
         UNIT0_SELECT_ADDR: w = {24'h00_0000, select0};
         UNIT1_SELECT_ADDR: w = {24'h00_0000, select1};
         OUT_CTRL_ADDR:     w = {16'h0000, slave_output_mode_bit, polarity};
         OUT_STATUS_ADDR:   w = {16'h0000, timer_output_pin,
                                 channel_running_flag};
         default:           w = 32'h0000_0000;
      endcase
      return w;
   endfunction : read_word

   // address phase capture; the write itself lands in the data phase
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wr_pend <= 1'b0;
         wr_addr <= 32'h0000_0000;
      end else if (hready) begin
         wr_pend <= addr_take && hwrite;
         wr_addr <= haddr;
      end
   end

   // read data is sampled at the address phase, so it stands a full cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_take && !hwrite) begin
         // RULE4 register placement
         hrdata <= read_word(haddr);
      end else if (hready) begin
         hrdata <= 32'h0000_0000;
      end
   end

   // select registers; the upper byte is not stored, software keeps it zero
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         // RULE3 select reset zero
         select0 <= SELECT_RST;
         select1 <= SELECT_RST;
      end else if (wr_pend) begin
         // RULE4 select write decode
         if (wr_addr == UNIT0_SELECT_ADDR) begin
            select0 <= hwdata[CLK1_LSB+CODE_W-1:CLK0_LSB];
         end
         if (wr_addr == UNIT1_SELECT_ADDR) begin
            select1 <= hwdata[CLK1_LSB+CODE_W-1:CLK0_LSB];
         end
      end
   end

   // output control register: polarity and slave output mode
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         polarity              <= POL_RST;
         slave_output_mode_bit <= MODE_RST;
      end else if (wr_pend && wr_addr == OUT_CTRL_ADDR) begin
         polarity              <= hwdata[POL_LSB+CH_NUM-1:POL_LSB];
         slave_output_mode_bit <= hwdata[MODE_LSB+CH_NUM-1:MODE_LSB];
      end
   end

   prescale_unit unit0 (
      .core_clk (core_clk),
      .rstn     (rstn),
      .codes    (select0),
      .op_en    (unit0_op_clk)
   );

   prescale_unit unit1 (
      .core_clk (core_clk),
      .rstn     (rstn),
      .codes    (select1),
      .op_en    (unit1_op_clk)
   );

   // next output state; a set in the same cycle as a reset wins
   always_comb begin
      next_active = out_active;
      next_pol    = eff_pol;
      for (int i = 0; i < CH_NUM; i++) begin
         // RULE8 set and reset events
         if (set_event[i]) begin
            next_active[i] = 1'b1;
         end else if (reset_event[i]) begin
            next_active[i] = 1'b0;
         end
         // RULE7 polarity deferred in slave mode
         if (!slave_output_mode_bit[i] || !channel_running_flag[i] ||
             set_event[i] || reset_event[i]) begin
            next_pol[i] = polarity[i];
         end
      end
   end

   // pin level is active state xor polarity; polarity one means active low
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         out_active       <= '0;
         eff_pol          <= POL_RST;
         timer_output_pin <= '0;
      end else begin
         out_active       <= next_active;
         eff_pol          <= next_pol;
         timer_output_pin <= next_active ^ next_pol;
      end
   end

   sequence quiet_slave0;
      slave_output_mode_bit[0] && channel_running_flag[0] &&
      !set_event[0] && !reset_event[0];
   endsequence

   reset_clears_a: assert property ( // RULE3
      @(posedge core_clk)
      !rstn |=> select0 == 8'h00 && select1 == 8'h00)
      else $error("select registers not cleared by reset");

   select_write_a: assert property ( // RULE4
      @(posedge core_clk) disable iff (!rstn)
      wr_pend && wr_addr == UNIT0_SELECT_ADDR |=>
         select0 == $past(hwdata[7:0]))
      else $error("unit 0 select write not stored");

   select_read_a: assert property ( // RULE3
      @(posedge core_clk) disable iff (!rstn)
      addr_take && !hwrite && haddr == UNIT1_SELECT_ADDR |=>
         hrdata == {24'h00_0000, $past(select1)})
      else $error("unit 1 select read returned wrong data");

   unmapped_zero_a: assert property ( // RULE4
      @(posedge core_clk) disable iff (!rstn)
      addr_take && !hwrite && haddr != UNIT0_SELECT_ADDR &&
         haddr != UNIT1_SELECT_ADDR && haddr != OUT_CTRL_ADDR &&
         haddr != OUT_STATUS_ADDR |=> hrdata == 32'h0000_0000)
      else $error("unmapped read must return zero");

   polarity_hold_a: assert property ( // RULE7
      @(posedge core_clk) disable iff (!rstn)
      quiet_slave0 ##1 quiet_slave0 |=> $stable(timer_output_pin[0]))
      else $error("output moved without an output event in slave mode");

   set_active_a: assert property ( // RULE8
      @(posedge core_clk) disable iff (!rstn)
      set_event[0] |=> timer_output_pin[0] == !$past(polarity[0]))
      else $error("set event did not drive the active level");

   reset_inactive_a: assert property ( // RULE8
      @(posedge core_clk) disable iff (!rstn)
      reset_event[0] && !set_event[0] |=>
         timer_output_pin[0] == $past(polarity[0]))
      else $error("reset event did not drive the inactive level");

   direct_pol_a: assert property ( // RULE7
      @(posedge core_clk) disable iff (!rstn)
      !slave_output_mode_bit[0] && !set_event[0] && !reset_event[0] |=>
         timer_output_pin[0] == ($past(out_active[0]) ^ $past(polarity[0])))
      else $error("outside slave mode polarity must follow at once");
endmodule : timer_prescaler_top
`default_nettype wire
